//--- common/cfpp_pkg.sv
// shared constants, types and helpers of the command flash parallel port
package cfpp_pkg;

    // ==========================================================
    // widths and field positions
    localparam int DATA_W = 8;
    localparam int ADDR_W = 22;
    localparam int LOW_MSB = 7;
    localparam int MID_LSB = 8;
    localparam int MID_MSB = 15;
    localparam int TOP_LSB = 16;
    localparam int TOP_MSB = 21;
    localparam int MODE_W = 3;
    localparam int CTRL_PINS = 6;

    // ==========================================================
    // operation codes
    localparam logic [MODE_W-1:0] MODE_PWRDN = 3'h0;
    localparam logic [MODE_W-1:0] MODE_READ = 3'h1;
    localparam logic [MODE_W-1:0] MODE_PROG = 3'h2;
    localparam logic [MODE_W-1:0] MODE_ERASE = 3'h3;
    localparam logic [MODE_W-1:0] MODE_VERIFY = 3'h4;

    // ==========================================================
    // reset, fill and step values
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
    localparam logic [DATA_W-1:0] SUM_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IDLE_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h00_0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 22'h00_0001;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_STEP = 32'h0000_0001;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;

    // ==========================================================
    // types
    typedef enum logic [1:0] {REG_LOW, REG_MID, REG_TOP, REG_MODE} cfpp_regsel_t;
    typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_HOLD} cfpp_state_t;

    // ==========================================================
    // helpers
    function automatic logic [DATA_W-1:0] fold(input logic [DATA_W-1:0] sum,
                                               input logic [DATA_W-1:0] data);
        fold = sum ^ data;
    endfunction

    function automatic logic mode_is_read(input logic [MODE_W-1:0] m);
        mode_is_read = (m == MODE_READ) || (m == MODE_VERIFY);
    endfunction

    function automatic logic mode_is_write(input logic [MODE_W-1:0] m);
        mode_is_write = (m == MODE_PROG) || (m == MODE_ERASE);
    endfunction

endpackage

//--- common/cfpp_mem_if.sv
// carrier between the port logic and its flash array model
`timescale 1ns/1ps
interface cfpp_mem_if #(
    parameter int AW = 19,
    parameter int DW = 8
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- hdl/cfpp_mem.sv
// byte array standing in for the flash cells, registered read data
`timescale 1ns/1ps
module cfpp_mem #(
    parameter int AW = 19,
    parameter int DW = 8
) (
    // clock
    input wire logic clk_i,
    input wire logic ce_i,
    // array port
    cfpp_mem_if.mem port
);

    // ==========================================================
    // storage
    // contents are unknown until erased, as on a fresh die
    logic [DW-1:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (ce_i && port.we) begin
            cells[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            port.rdata <= cells[port.raddr];
        end
    end

endmodule

//--- hdl/cfpp_top.sv
// device side of the command flash parallel host port
// Functional notes
// - parallel port acts only while interface select is high; low means serial.
// - device selected only with high-active select high and low-active select low.
// - read/write high reads, low writes; array/register high picks array, low registers.
// - busy is high while the array is occupied by program or erase.
// - the strobe pin clocks every register and array transfer.
// - address held in low byte, middle byte and six top bits.
// - address pointer adds one after each completed array data access.
// - checksum XORs every byte written to or read from the array.
// - checksum is read back by a register read; cleared by any address or mode register write.
// - three-bit mode: off, read, program, erase, verify; resets to off.
// - read modes act on data reads, write modes act on data writes.
// - power-down takes effect once the loaded mode zero has crossed into the system clock domain.
// - all parallel traffic uses the eight-bit two-way data bus.
// - strobe pulse with both control lines low writes a register, clears checksum.
// - register writes rotate low, middle, top, mode, then back to low.
// - register rotation restarts on data access or on deselect and reselect.
// - array write: strobe with array selected, write, mode program or erase.
// - busy rises after strobe falls, falls when program or erase ends.
// - strobe rise ending array write folds byte and advances pointer.
// - array read shows byte while strobe low; rise advances, folds, restarts rotation.
`timescale 1ns/1ps
module cfpp_top #(
    parameter int MEM_AW = 19,
    parameter int PAGE_AW = 8,
    parameter int PROG_TIME_NS = 1000,
    parameter int ERASE_TIME_NS = 6000
) (
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // strobe pin, clock of the link domain
    input wire logic strobe_clk_i,
    // selects and access control
    input wire logic iface_select_i,
    input wire logic select_high_active_i,
    input wire logic select_low_active_n_i,
    input wire logic read_not_write_i,
    input wire logic array_or_reg_sel_i,
    // two-way data bus
    input wire logic [cfpp_pkg::DATA_W-1:0] data_i,
    output logic [cfpp_pkg::DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    // status
    output logic busy_o,
    output logic power_down_o
);

    // ==========================================================
    // derived counts
    localparam int PROG_CYC_RAW = (PROG_TIME_NS + cfpp_pkg::CLK_PERIOD_NS - 1)
                                  / cfpp_pkg::CLK_PERIOD_NS;
    localparam int ERASE_CYC_RAW = (ERASE_TIME_NS + cfpp_pkg::CLK_PERIOD_NS - 1)
                                   / cfpp_pkg::CLK_PERIOD_NS;
    localparam int PROG_CYC = (PROG_CYC_RAW < 1) ? 1 : PROG_CYC_RAW;
    localparam int ERASE_CYC = (ERASE_CYC_RAW < 1) ? 1 : ERASE_CYC_RAW;
    localparam int PAGE_BYTES = 1 << PAGE_AW;
    localparam int PIN_W = cfpp_pkg::CTRL_PINS + cfpp_pkg::DATA_W;
    // strobe idles high; a low reset copy would fake a strobe fall after reset
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, {(PIN_W-1){1'b0}}};

    // ==========================================================
    // elaboration checks
    generate
        if (MEM_AW > cfpp_pkg::ADDR_W || MEM_AW <= PAGE_AW || PAGE_AW < 1) begin : g_bad_aw
            $error("cfpp_top: array or page address width out of range");
        end
        if (ERASE_CYC < PAGE_BYTES) begin : g_bad_erase
            $error("cfpp_top: erase time too short to clear a whole page");
        end
    endgenerate

    // ==========================================================
    // link domain (strobe clock)
    logic link_sel;
    logic link_rot_rst;
    logic link_reg_wr;
    logic link_arr_wr;
    logic link_arr_rd;
    logic link_data_acc;
    cfpp_pkg::cfpp_regsel_t regsel_q;
    logic [cfpp_pkg::ADDR_W-1:0] addr_ptr_q;
    logic [cfpp_pkg::MODE_W-1:0] mode_q;
    logic mode_tgl_q;
    logic [cfpp_pkg::DATA_W-1:0] sum_q;
    logic [cfpp_pkg::DATA_W-1:0] bus_data_q;

    // the pins are synchronous to the strobe, so the link side reads them directly
    assign link_sel = select_high_active_i & ~select_low_active_n_i & iface_select_i;
    assign link_reg_wr = link_sel & ~array_or_reg_sel_i & ~read_not_write_i;
    assign link_arr_wr = link_sel & array_or_reg_sel_i & ~read_not_write_i
                         & cfpp_pkg::mode_is_write(mode_q);
    assign link_arr_rd = link_sel & array_or_reg_sel_i & read_not_write_i
                         & cfpp_pkg::mode_is_read(mode_q);
    assign link_data_acc = link_sel & array_or_reg_sel_i;

    // the strobe stands still while deselected, so deselection restarts the rotation
    // asynchronously; a glitch on the selects can only restart it early, never skip
    assign link_rot_rst = rst_i | ~(select_high_active_i & ~select_low_active_n_i);

    always_ff @(posedge strobe_clk_i or posedge link_rot_rst) begin
        if (link_rot_rst) begin
            regsel_q <= cfpp_pkg::REG_LOW;
        end else if (link_data_acc) begin
            regsel_q <= cfpp_pkg::REG_LOW;
        end else if (link_reg_wr) begin
            case (regsel_q)
                cfpp_pkg::REG_LOW: regsel_q <= cfpp_pkg::REG_MID;
                cfpp_pkg::REG_MID: regsel_q <= cfpp_pkg::REG_TOP;
                cfpp_pkg::REG_TOP: regsel_q <= cfpp_pkg::REG_MODE;
                default: regsel_q <= cfpp_pkg::REG_LOW;
            endcase
        end
    end

    always_ff @(posedge strobe_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_ptr_q <= cfpp_pkg::ADDR_RESET;
        end else if (link_reg_wr) begin
            case (regsel_q)
                cfpp_pkg::REG_LOW: begin
                    addr_ptr_q[cfpp_pkg::LOW_MSB:0] <= data_i;
                end
                cfpp_pkg::REG_MID: begin
                    addr_ptr_q[cfpp_pkg::MID_MSB:cfpp_pkg::MID_LSB] <= data_i;
                end
                cfpp_pkg::REG_TOP: begin
                    addr_ptr_q[cfpp_pkg::TOP_MSB:cfpp_pkg::TOP_LSB] <=
                        data_i[cfpp_pkg::TOP_MSB-cfpp_pkg::TOP_LSB:0];
                end
                default: begin
                    addr_ptr_q <= addr_ptr_q;
                end
            endcase
        end else if (link_arr_wr || link_arr_rd) begin
            addr_ptr_q <= addr_ptr_q + cfpp_pkg::ADDR_STEP;
        end
    end

    // deselected strobes fall through every branch, so nothing moves
    always_ff @(posedge strobe_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= cfpp_pkg::MODE_RESET;
            mode_tgl_q <= 1'b0;
        end else if (link_reg_wr && regsel_q == cfpp_pkg::REG_MODE) begin
            mode_q <= data_i[cfpp_pkg::MODE_W-1:0];
            mode_tgl_q <= ~mode_tgl_q;
        end
    end

    always_ff @(posedge strobe_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sum_q <= cfpp_pkg::SUM_RESET;
        end else if (link_reg_wr) begin
            sum_q <= cfpp_pkg::SUM_RESET;
        end else if (link_arr_wr) begin
            sum_q <= cfpp_pkg::fold(sum_q, data_i);
        end else if (link_arr_rd) begin
            // the byte on the bus has been steady since a few system cycles after the strobe fell
            sum_q <= cfpp_pkg::fold(sum_q, bus_data_q);
        end
    end

    // ==========================================================
    // system domain: pin synchronisers
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;
    logic s_strobe;
    logic s_cs_hi;
    logic s_cs_lo_n;
    logic s_iface;
    logic s_rw;
    logic s_dc;
    logic [cfpp_pkg::DATA_W-1:0] s_data;
    logic strobe_prev_q;
    logic tgl_meta_q;
    logic tgl_sync_q;
    logic tgl_prev_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= PIN_IDLE;
            pin_sync_q <= PIN_IDLE;
            tgl_meta_q <= 1'b0;
            tgl_sync_q <= 1'b0;
        end else if (ce_i) begin
            pin_meta_q <= {strobe_clk_i, select_high_active_i, select_low_active_n_i,
                           iface_select_i, read_not_write_i, array_or_reg_sel_i, data_i};
            pin_sync_q <= pin_meta_q;
            tgl_meta_q <= mode_tgl_q;
            tgl_sync_q <= tgl_meta_q;
        end
    end

    assign {s_strobe, s_cs_hi, s_cs_lo_n, s_iface, s_rw, s_dc, s_data} = pin_sync_q;

    // ==========================================================
    // system domain: mode copy and power-down
    logic s_sel;
    logic strobe_fall;
    logic [cfpp_pkg::MODE_W-1:0] mode_s_q;
    logic power_down_q;

    assign s_sel = s_cs_hi & ~s_cs_lo_n & s_iface;
    assign strobe_fall = strobe_prev_q & ~s_strobe;

    // the mode word is steady long before its toggle arrives, so it is sampled whole
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_prev_q <= 1'b1;
            tgl_prev_q <= 1'b0;
            mode_s_q <= cfpp_pkg::MODE_RESET;
            power_down_q <= 1'b1;
        end else if (ce_i) begin
            strobe_prev_q <= s_strobe;
            tgl_prev_q <= tgl_sync_q;
            if (tgl_sync_q != tgl_prev_q) begin
                mode_s_q <= mode_q;
                power_down_q <= (mode_q == cfpp_pkg::MODE_PWRDN);
            end
        end
    end

    // ==========================================================
    // system domain: program and erase sequencer
    cfpp_pkg::cfpp_state_t state_q;
    logic [31:0] cnt_q;
    logic busy_q;
    logic [cfpp_pkg::ADDR_W-1:0] addr_s_q;
    logic mem_we_q;
    logic [MEM_AW-1:0] mem_waddr_q;
    logic [cfpp_pkg::DATA_W-1:0] mem_wdata_q;
    logic arr_wr_start;

    assign arr_wr_start = (state_q == cfpp_pkg::ST_IDLE) & strobe_fall & s_sel
                          & s_dc & ~s_rw;

    // the pointer only moves on a strobe rise, so it is steady at a synced fall
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_s_q <= cfpp_pkg::ADDR_RESET;
        end else if (ce_i && strobe_fall) begin
            addr_s_q <= addr_ptr_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= cfpp_pkg::ST_IDLE;
            cnt_q <= cfpp_pkg::CNT_RESET;
            busy_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_waddr_q <= '0;
            mem_wdata_q <= cfpp_pkg::IDLE_BYTE;
        end else if (ce_i) begin
            mem_we_q <= 1'b0;
            case (state_q)
                cfpp_pkg::ST_IDLE: begin
                    cnt_q <= cfpp_pkg::CNT_RESET;
                    if (arr_wr_start && mode_s_q == cfpp_pkg::MODE_PROG) begin
                        // data and controls are held by the host until busy falls
                        mem_we_q <= 1'b1;
                        mem_waddr_q <= addr_ptr_q[MEM_AW-1:0];
                        mem_wdata_q <= s_data;
                        busy_q <= 1'b1;
                        state_q <= cfpp_pkg::ST_PROG;
                    end else if (arr_wr_start && mode_s_q == cfpp_pkg::MODE_ERASE) begin
                        busy_q <= 1'b1;
                        state_q <= cfpp_pkg::ST_ERASE;
                    end
                end
                cfpp_pkg::ST_PROG: begin
                    cnt_q <= cnt_q + cfpp_pkg::CNT_STEP;
                    if (cnt_q == 32'(PROG_CYC - 1)) begin
                        busy_q <= 1'b0;
                        state_q <= cfpp_pkg::ST_HOLD;
                    end
                end
                cfpp_pkg::ST_ERASE: begin
                    cnt_q <= cnt_q + cfpp_pkg::CNT_STEP;
                    if (cnt_q < 32'(PAGE_BYTES)) begin
                        mem_we_q <= 1'b1;
                        mem_waddr_q <= {addr_s_q[MEM_AW-1:PAGE_AW], cnt_q[PAGE_AW-1:0]};
                        mem_wdata_q <= cfpp_pkg::BLANK_BYTE;
                    end
                    if (cnt_q == 32'(ERASE_CYC - 1)) begin
                        busy_q <= 1'b0;
                        state_q <= cfpp_pkg::ST_HOLD;
                    end
                end
                cfpp_pkg::ST_HOLD: begin
                    // one operation per strobe: wait for the rise that ends it
                    if (s_strobe) begin
                        state_q <= cfpp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    busy_q <= 1'b0;
                    state_q <= cfpp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // flash array
    cfpp_mem_if #(.AW(MEM_AW), .DW(cfpp_pkg::DATA_W)) mem_bus ();

    assign mem_bus.we = mem_we_q;
    assign mem_bus.waddr = mem_waddr_q;
    assign mem_bus.wdata = mem_wdata_q;
    assign mem_bus.raddr = addr_s_q[MEM_AW-1:0];

    cfpp_mem #(
        .AW(MEM_AW),
        .DW(cfpp_pkg::DATA_W)
    ) u_mem (
        .clk_i(sys_clk_i),
        .ce_i(ce_i),
        .port(mem_bus.mem)
    );

    // ==========================================================
    // system domain: data bus drive
    logic rd_active;

    // release lags the strobe rise by the synchroniser depth, about three cycles
    assign rd_active = s_sel & ~s_strobe & s_rw & (state_q == cfpp_pkg::ST_IDLE);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_oe_n_o <= 1'b1;
            bus_data_q <= cfpp_pkg::IDLE_BYTE;
        end else if (ce_i) begin
            data_oe_n_o <= ~rd_active;
            if (rd_active && s_dc) begin
                // array byte only in a read mode; checksum copy is steady while strobe is low
                bus_data_q <= cfpp_pkg::mode_is_read(mode_s_q) ? mem_bus.rdata
                                                               : cfpp_pkg::IDLE_BYTE;
            end else if (rd_active) begin
                bus_data_q <= sum_q;
            end
        end
    end

    assign data_o = bus_data_q;
    assign busy_o = busy_q;
    assign power_down_o = power_down_q;

endmodule

//--- testbench/cfpp_top_asserts.sv
// pin level checks of the command flash parallel port
`timescale 1ns/1ps
module cfpp_top_asserts (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // host pins
    input wire logic strobe_clk_i,
    input wire logic iface_select_i,
    input wire logic select_high_active_i,
    input wire logic select_low_active_n_i,
    input wire logic read_not_write_i,
    input wire logic array_or_reg_sel_i,
    input wire logic [cfpp_pkg::DATA_W-1:0] data_i,
    // device pins
    input wire logic [cfpp_pkg::DATA_W-1:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic busy_o,
    input wire logic power_down_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic act;
    logic rd_cond;
    logic wr_cond;
    logic strobe_q;
    logic [7:0] since_rise_q;
    assign act = select_high_active_i && !select_low_active_n_i && iface_select_i && !strobe_clk_i;
    assign rd_cond = act && read_not_write_i;
    assign wr_cond = act && array_or_reg_sel_i && !read_not_write_i;
    // cycles since the strobe last rose, saturating
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_q <= 1'b1;
            since_rise_q <= 8'hff;
        end else begin
            strobe_q <= strobe_clk_i;
            if (strobe_clk_i && !strobe_q) begin
                since_rise_q <= 8'h00;
            end else if (ce_i && since_rise_q != 8'hff) begin
                since_rise_q <= since_rise_q + 8'h01;
            end
        end
    end
    a_drive_needs_read: assert property ($fell(data_oe_n_o) |-> $past(rd_cond))
        else $error("bus driven without a selected read");
    a_bus_idle_quiet: assert property ((!rd_cond) [*6] |-> data_oe_n_o)
        else $error("bus still driven long after read ended");
    a_busy_needs_write: assert property ($rose(busy_o) |-> $past(wr_cond) && !power_down_o)
        else $error("busy rose without an array write");
    a_busy_min_len: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("busy dropped too early");
    a_busy_ends_bound: assert property ($rose(busy_o) |-> ##[1:40] !busy_o)
        else $error("busy never fell");
    a_no_drive_busy: assert property (busy_o |-> data_oe_n_o)
        else $error("bus driven during array write");
    a_busy_not_off: assert property (busy_o |-> !power_down_o)
        else $error("busy while powered down");
    a_mode_after_strobe: assert property ($changed(power_down_o) |-> since_rise_q < 8'h08)
        else $error("power down changed without a strobe");
endmodule

//--- testbench/cfpp_host_model.sv
// behavioural microcontroller driving the strobe, selects and data bus
`timescale 1ns/1ps
module cfpp_host_model (
    // clock
    input wire logic clk_i,
    // device outputs
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_n_i,
    input wire logic busy_i,
    // pins toward the device
    output logic strobe_o,
    output logic iface_o,
    output logic sel_hi_o,
    output logic sel_lo_n_o,
    output logic rw_o,
    output logic dc_o,
    output logic [7:0] bus_o
);
    logic drv_q = 1'b0;
    logic [7:0] wdat_q = 8'h00;
    initial begin
        strobe_o = 1'b1;
        iface_o = 1'b1;
        sel_hi_o = 1'b0;
        sel_lo_n_o = 1'b1;
        rw_o = 1'b1;
        dc_o = 1'b0;
    end
    // released bus shows the inverse of the last byte, no keeper on the wire
    assign bus_o = !dev_oe_n_i ? dev_data_i : (drv_q ? wdat_q : ~wdat_q);
    task automatic sel(input logic hi, input logic lo_n, input logic ifc);
        @(posedge clk_i);
        sel_hi_o <= hi;
        sel_lo_n_o <= lo_n;
        iface_o <= ifc;
        repeat (3) @(posedge clk_i);
    endtask
    // one strobe pulse; low_cyc sets how slowly the host answers
    task automatic acc(input logic rw, input logic dc, input logic [7:0] d, input int low_cyc,
                       output logic [7:0] q, output logic saw_busy);
        int n;
        @(posedge clk_i);
        rw_o <= rw;
        dc_o <= dc;
        wdat_q <= d;
        drv_q <= !rw;
        strobe_o <= 1'b0;
        // busy may come and go within the low phase, so watch every edge
        saw_busy = 1'b0;
        repeat (low_cyc) begin
            @(posedge clk_i);
            saw_busy = saw_busy | busy_i;
        end
        // strobe, controls and data held until busy falls
        for (n = 0; n < 60 && busy_i; n++) begin
            @(posedge clk_i);
        end
        q = bus_o;
        strobe_o <= 1'b1;
        @(posedge clk_i);
        drv_q <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

//--- testbench/cfpp_top_test.sv
// self-checking bench of the command flash parallel port
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cfpp_top_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic link_clk = 1'b0;
    logic ce = 1'b1;
    logic strobe, iface, sel_hi, sel_lo_n, rw, dc, oe_n, busy, pwr_dn;
    logic [7:0] bus, dout, rq;
    logic rb;
    int err_count = 0;
    int check_count = 0;
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // host runs on its own clock, never in step with the system clock
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    cfpp_host_model cfpp_host_model_inst (.clk_i(link_clk), .dev_data_i(dout), .dev_oe_n_i(oe_n),
        .busy_i(busy), .strobe_o(strobe), .iface_o(iface), .sel_hi_o(sel_hi),
        .sel_lo_n_o(sel_lo_n), .rw_o(rw), .dc_o(dc), .bus_o(bus));
    // shortened array and timings keep the run small
    cfpp_top #(.MEM_AW(10), .PAGE_AW(4), .PROG_TIME_NS(200), .ERASE_TIME_NS(400)) cfpp_top_inst (
        .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .strobe_clk_i(strobe),
        .iface_select_i(iface), .select_high_active_i(sel_hi), .select_low_active_n_i(sel_lo_n),
        .read_not_write_i(rw), .array_or_reg_sel_i(dc), .data_i(bus), .data_o(dout),
        .data_oe_n_o(oe_n), .busy_o(busy), .power_down_o(pwr_dn));
    // ==========================================================
    // access tasks
    task automatic wr(input logic [7:0] d);
        cfpp_host_model_inst.acc(1'b0, 1'b0, d, 4, rq, rb);
    endtask
    task automatic regs(input logic [21:0] a, input logic [2:0] m);
        wr(a[7:0]);
        wr(a[15:8]);
        wr({2'b00, a[21:16]});
        wr({5'h00, m});
    endtask
    task automatic dat(input logic r, input logic [7:0] d);
        cfpp_host_model_inst.acc(r, 1'b1, d, 7, rq, rb);
    endtask
    task automatic sum();
        cfpp_host_model_inst.acc(1'b1, 1'b0, 8'h00, 7, rq, rb);
    endtask
    task automatic complete_run();
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(pwr_dn, 1'b1)
        `CHK(oe_n, 1'b1)
        cfpp_host_model_inst.sel(1'b1, 1'b0, 1'b1);
        // a frozen system side must not take the new mode until enabled again
        @(posedge sys_clk);
        ce <= 1'b0;
        regs(22'h00_0005, cfpp_pkg::MODE_PROG);
        `CHK(pwr_dn, 1'b1)
        @(posedge sys_clk);
        ce <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK(pwr_dn, 1'b0)
        dat(1'b0, 8'h3c);
        `CHK(rb, 1'b1)
        dat(1'b0, 8'ha5);
        `CHK(rb, 1'b1)
        sum();
        `CHK(rq, 8'h99)
        regs(22'h00_0005, cfpp_pkg::MODE_READ);
        sum();
        `CHK(rq, 8'h00)
        dat(1'b1, 8'h00);
        `CHK(rq, 8'h3c)
        dat(1'b1, 8'h00);
        `CHK(rq, 8'ha5)
        sum();
        `CHK(rq, 8'h99)
        dat(1'b0, 8'h11);
        `CHK(rb, 1'b0)
        wr(8'hee);
        wr(8'hee);
        dat(1'b1, 8'h00);
        regs(22'h00_0005, cfpp_pkg::MODE_READ);
        dat(1'b1, 8'h00);
        `CHK(rq, 8'h3c)
        wr(8'hee);
        cfpp_host_model_inst.sel(1'b0, 1'b0, 1'b1);
        cfpp_host_model_inst.sel(1'b1, 1'b0, 1'b1);
        regs(22'h00_0006, cfpp_pkg::MODE_READ);
        dat(1'b1, 8'h00);
        `CHK(rq, 8'ha5)
        cfpp_host_model_inst.sel(1'b1, 1'b1, 1'b1);
        regs(22'h00_0000, cfpp_pkg::MODE_PWRDN);
        `CHK(pwr_dn, 1'b0)
        cfpp_host_model_inst.sel(1'b1, 1'b0, 1'b0);
        regs(22'h00_0000, cfpp_pkg::MODE_PWRDN);
        `CHK(pwr_dn, 1'b0)
        cfpp_host_model_inst.sel(1'b0, 1'b1, 1'b1);
        cfpp_host_model_inst.sel(1'b1, 1'b0, 1'b1);
        regs(22'h00_0005, cfpp_pkg::MODE_ERASE);
        dat(1'b0, 8'h00);
        `CHK(rb, 1'b1)
        regs(22'h00_0005, cfpp_pkg::MODE_VERIFY);
        dat(1'b1, 8'h00);
        `CHK(rq, 8'hff)
        dat(1'b1, 8'h00);
        `CHK(rq, 8'hff)
        regs(22'h00_0000, cfpp_pkg::MODE_PWRDN);
        `CHK(pwr_dn, 1'b1)
        dat(1'b0, 8'h22);
        `CHK(rb, 1'b0)
        complete_run();
    end
    // a hang is cut short well past the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end
endmodule
bind cfpp_top cfpp_top_asserts cfpp_top_asserts_inst (.sys_clk_i, .rst_i, .ce_i, .strobe_clk_i,
    .iface_select_i, .select_high_active_i, .select_low_active_n_i, .read_not_write_i,
    .array_or_reg_sel_i, .data_i, .data_o, .data_oe_n_o, .busy_o, .power_down_o);
